// [logic/fpbl_map.vh]
`ifndef FPBL_MAP_VH
`define FPBL_MAP_VH
// clock rate and the millisecond divider
`define FPBL_CLK_KHZ      20000
`define FPBL_MS_CYC       (`FPBL_CLK_KHZ)
// times in milliseconds
`define FPBL_DEB_MS       20
`define FPBL_BOOT_MS      40
`define FPBL_LOCK_WIN_MS  100
`define FPBL_HOLD_BLK_MS  5000
`define FPBL_HOLD_FAC_MS  10000
`define FPBL_DHCP_MS      5000
`define FPBL_DARK_MS      1000
`define FPBL_SLOW_HALF_MS 500
`define FPBL_FAST_HALF_MS 100
// flash halves are sized to the 8-bit half register they load
`define FPBL_FLASH_HALF_MS 8'hFA
`define FPBL_QUICK_HALF_MS 8'h64
// blink counts, sized to the 4-bit argument of the halves function
`define FPBL_AMBER_BLINKS 4'h6
`define FPBL_LOCK_BLINKS  4'h4
`define FPBL_DENY_BLINKS  4'h3
// selection codes: 0..3 inputs, then automatic
`define FPBL_SEL_AUTO     3'h4
`define FPBL_SEL_FIRST    3'h0
// audio route source codes
`define FPBL_RT_ORIG      2'h0
`define FPBL_RT_OUT1      2'h1
`define FPBL_RT_SECOND_OUTPUT_SELECT      2'h2
`define FPBL_RT_ANALOG    2'h3
// register offsets
`define FPBL_REG_CTRL     4'h0
`define FPBL_REG_STATUS   4'h4
`define FPBL_REG_SEL      4'h8
// control register fields
`define FPBL_CTRL_DHCP    0
`define FPBL_CTRL_LOCK    1
`endif

// [logic/fpbl_debounce.v]
`timescale 1ns/1ns
`include "fpbl_map.vh"
// two-flop synchroniser plus a stability filter counted in milliseconds
module fpbl_debounce #(
	parameter DEB_MS = `FPBL_DEB_MS	// time the pin must stay steady
) (
	// clock and reset
	input  wire mclk,
	input  wire srst,
	// millisecond enable
	input  wire tick_ms,
	// raw button pin, active high
	input  wire pin,
	// filtered level and one-cycle press pulse
	output reg  level_r,
	output reg  press_r
);
	reg       sync0_r;	// first stage, read only by sync1_r
	reg       sync1_r;	// second stage
	reg [7:0] cnt_r;	// ms the pin has differed from level_r

	// synchronise, then accept a new level only after it held long enough
	always @(posedge mclk) begin
		if (srst) begin
			sync0_r <= 1'b0;
			sync1_r <= 1'b0;
			cnt_r   <= 8'h00;
			level_r <= 1'b0;
			press_r <= 1'b0;
		end else begin
			sync0_r <= pin;
			sync1_r <= sync0_r;
			press_r <= 1'b0;
			if (sync1_r == level_r) begin
				cnt_r <= 8'h00;	// bounce restarts the wait
			end else if (tick_ms) begin
				if (cnt_r == DEB_MS[7:0] - 8'h01) begin
					level_r <= sync1_r;
					press_r <= sync1_r;	// one press, one pulse
					cnt_r   <= 8'h00;
				end else begin
					cnt_r <= cnt_r + 8'h01;
				end
			end
		end
	end
endmodule // fpbl_debounce

// [logic/fpbl_ctrl.v]
`timescale 1ns/1ns
`include "fpbl_map.vh"
// Notes on behaviour
// R1: input indicator green only with signal
// R2: link indicator dark, blinking, or steady
// R3: output indicator green when present, unmuted
// R4: protection indicator off, steady, or blinking
// R5: select press steps output source
// R6: auto wraps to first; presses debounced
// R7: audio press loads next preset cyclically
// R8: preset n blinks input n amber six
// R9: presets route audio as tabulated
// R10: static addressing default; gesture enables dynamic
// R11: audio hold blinks at 5s, resets 10s
// R12: factory reset darkens, restores, reboots
// R13: reset button reboots, keeps settings
// R14: slow heartbeat again after reboot
// R15: paired press within 100ms toggles lock
// R16: locked presses ignored, quick triple blink
// R17: audio held at power-on enters upgrade
// R18: upgrade mode: fast heartbeat, others dark
// R19: normal operation blinks heartbeat slowly
module fpbl_ctrl #(
	parameter MS_CYC = `FPBL_MS_CYC	// clock cycles per millisecond
) (
	// clock and reset
	input  wire       mclk,
	input  wire       srst,
	// register port
	input  wire [3:0] reg_addr,
	input  wire [7:0] reg_wdata,
	input  wire       reg_wr,
	input  wire       reg_rd,
	output reg  [7:0] reg_rdata_r,
	// button pins, active high
	input  wire       btn_sel1,
	input  wire       btn_sel2,
	input  wire       btn_audio,
	input  wire       btn_reset,
	// status from the switching logic
	input  wire [3:0] in_sig,
	input  wire       tp_link,
	input  wire       tp_lowpwr,
	input  wire [1:0] out_sig,
	input  wire [1:0] out_mute,
	input  wire [1:0] out_enc,
	input  wire [1:0] out_incap,
	// rear indicators
	output reg  [3:0] led_in_r,
	output reg        led_tp_r,
	output reg  [1:0] led_out_r,
	output reg  [1:0] led_prot_r,
	// front indicators
	output reg        heartbeat_indicator_r,
	output reg  [1:0] led_auto_r,
	output reg  [3:0] led_sel_green_r,
	output reg  [3:0] led_sel_amber_r,
	// requests to the rest of the system
	output reg  [2:0] sel1_r,
	output reg  [2:0] sel2_r,
	output reg  [1:0] route_out1_r,
	output reg  [1:0] route_second_output_select_r,
	output reg  [1:0] route_analog_r,
	output reg        dhcp_en_r,
	output reg        factory_req_r,
	output reg        reboot_req_r,
	output reg        fw_mode_r
);
	// one-hot operating modes
	localparam [3:0] ST_BOOT = 4'h1;	// strap window after reset
	localparam [3:0] ST_RUN  = 4'h2;	// normal operation
	localparam [3:0] ST_FW   = 4'h4;	// forced firmware upgrade
	localparam [3:0] ST_DARK = 4'h8;	// leds dark after a gesture

	reg  [3:0]  st_r;	// mode
	reg  [15:0] div_r;	// ms divider
	reg         tick_r;	// one-cycle ms enable
	reg  [8:0]  slow_ms_r;	// heartbeat slow phase timer
	reg  [8:0]  fast_ms_r;	// fast phase timer
	reg         slow_r;	// slow blink phase
	reg         fast_r;	// fast blink phase
	reg  [6:0]  boot_ms_r;	// strap window timer
	reg  [1:0]  preset_r;	// 0..3 means preset 1..4
	reg         lock_r;	// front panel lock
	reg         pend2_r;	// sel2 press awaiting partner
	reg         penda_r;	// audio press awaiting partner
	reg  [6:0]  win_r;	// ms since the first pending press
	reg  [13:0] hold_a_r;	// audio hold time
	reg  [13:0] hold_1_r;	// sel1 hold time
	reg         fac_r;	// factory request issued, stay dark
	reg  [9:0]  dark_ms_r;	// dark timer after dhcp gesture
	reg  [3:0]  fl_cnt_r;	// front flash halves left
	reg  [7:0]  fl_ms_r;	// ms into current flash half
	reg  [7:0]  fl_half_r;	// length of a flash half
	reg         fl_on_r;	// flash phase
	reg  [3:0]  am_cnt_r;	// amber halves left
	reg  [7:0]  am_ms_r;	// ms into current amber half
	wire        lvl1, lvl2, lvla, lvlr;	// filtered levels
	wire        p1, p2, pa, pr;	// press pulses
	wire        pair;	// both paired buttons seen in the window
	wire        win_end;	// pairing window over
	wire        hold_blink;	// long audio hold in progress

	// next source in the sequence, wrapping after automatic
	function [2:0] next_sel;
		input [2:0] cur;
		begin
			if (cur == `FPBL_SEL_AUTO)
				next_sel = `FPBL_SEL_FIRST;	// R6
			else
				next_sel = cur + 3'h1;	// R5
		end
	endfunction

	// number of flash halves for n blinks: twice n, taken from its low three bits
	function [3:0] halves;
		input [3:0] n;
		begin
			halves = {n[2:0], 1'b0};
		end
	endfunction

	// four identical debouncers, one per button
	fpbl_debounce #(.DEB_MS(`FPBL_DEB_MS)) u_db1 (.mclk(mclk), .srst(srst), .tick_ms(tick_r),
		.pin(btn_sel1), .level_r(lvl1), .press_r(p1));	// R6
	fpbl_debounce #(.DEB_MS(`FPBL_DEB_MS)) u_db2 (.mclk(mclk), .srst(srst), .tick_ms(tick_r),
		.pin(btn_sel2), .level_r(lvl2), .press_r(p2));
	fpbl_debounce #(.DEB_MS(`FPBL_DEB_MS)) u_dba (.mclk(mclk), .srst(srst), .tick_ms(tick_r),
		.pin(btn_audio), .level_r(lvla), .press_r(pa));
	fpbl_debounce #(.DEB_MS(`FPBL_DEB_MS)) u_dbr (.mclk(mclk), .srst(srst), .tick_ms(tick_r),
		.pin(btn_reset), .level_r(lvlr), .press_r(pr));

	assign pair       = (p2 | pend2_r) & (pa | penda_r) & (p2 | pa);
	assign win_end    = tick_r & (win_r == `FPBL_LOCK_WIN_MS - 1);
	assign hold_blink = lvla & ~lock_r & (hold_a_r >= `FPBL_HOLD_BLK_MS);

	// ms divider and the two free-running blink phases
	always @(posedge mclk) begin
		if (srst) begin
			div_r     <= 16'h0000;
			tick_r    <= 1'b0;
			slow_ms_r <= 9'h000;
			fast_ms_r <= 9'h000;
			slow_r    <= 1'b0;
			fast_r    <= 1'b0;
		end else begin
			tick_r <= (div_r == MS_CYC[15:0] - 16'h0001);
			div_r  <= (div_r == MS_CYC[15:0] - 16'h0001) ? 16'h0000 : div_r + 16'h0001;
			if (tick_r) begin
				if (slow_ms_r == `FPBL_SLOW_HALF_MS - 1) begin
					slow_ms_r <= 9'h000;
					slow_r    <= ~slow_r;
				end else begin
					slow_ms_r <= slow_ms_r + 9'h001;
				end
				if (fast_ms_r == `FPBL_FAST_HALF_MS - 1) begin
					fast_ms_r <= 9'h000;
					fast_r    <= ~fast_r;	// 200 ms cycle
				end else begin
					fast_ms_r <= fast_ms_r + 9'h001;
				end
			end
		end
	end

	// mode, buttons, lock, gestures and requests
	always @(posedge mclk) begin
		if (srst) begin
			st_r          <= ST_BOOT;
			boot_ms_r     <= 7'h00;
			sel1_r        <= `FPBL_SEL_FIRST;
			sel2_r        <= `FPBL_SEL_FIRST;
			preset_r      <= 2'h0;
			lock_r        <= 1'b0;
			pend2_r       <= 1'b0;
			penda_r       <= 1'b0;
			win_r         <= 7'h00;
			hold_a_r      <= 14'h0000;
			hold_1_r      <= 14'h0000;
			fac_r         <= 1'b0;
			dark_ms_r     <= 10'h000;
			dhcp_en_r     <= 1'b0;	// R10
			factory_req_r <= 1'b0;
			reboot_req_r  <= 1'b0;
			fw_mode_r     <= 1'b0;
			fl_cnt_r      <= 4'h0;
			fl_ms_r       <= 8'h00;
			fl_half_r     <= `FPBL_FLASH_HALF_MS;
			fl_on_r       <= 1'b0;
			am_cnt_r      <= 4'h0;
			am_ms_r       <= 8'h00;
		end else begin
			factory_req_r <= 1'b0;
			reboot_req_r  <= pr;	// R13
			// flash engine runs down on its own
			if (tick_r && fl_cnt_r != 4'h0) begin
				if (fl_ms_r == fl_half_r - 8'h01) begin
					fl_ms_r  <= 8'h00;
					fl_on_r  <= ~fl_on_r;
					fl_cnt_r <= fl_cnt_r - 4'h1;
				end else begin
					fl_ms_r <= fl_ms_r + 8'h01;
				end
			end
			// amber engine for the loaded preset
			if (tick_r && am_cnt_r != 4'h0) begin
				if (am_ms_r == `FPBL_FLASH_HALF_MS - 1) begin
					am_ms_r  <= 8'h00;
					am_cnt_r <= am_cnt_r - 4'h1;	// R8
				end else begin
					am_ms_r <= am_ms_r + 8'h01;
				end
			end
			// software write to control; a gesture in the same cycle wins
			if (reg_wr && reg_addr == `FPBL_REG_CTRL) begin
				dhcp_en_r <= reg_wdata[`FPBL_CTRL_DHCP];
				lock_r    <= reg_wdata[`FPBL_CTRL_LOCK];
			end
			case (st_r)
				ST_BOOT: begin
					// wait out the debouncer before trusting the strap
					if (tick_r)
						boot_ms_r <= boot_ms_r + 7'h01;
					if (boot_ms_r == `FPBL_BOOT_MS) begin
						st_r      <= lvla ? ST_FW : ST_RUN;	// R17
						fw_mode_r <= lvla;	// R17
					end
				end
				ST_FW: begin
					st_r <= ST_FW;	// only a reset leaves upgrade mode
				end
				ST_DARK: begin
					// factory stays dark until the reboot resets us
					if (tick_r && !fac_r) begin
						if (dark_ms_r == `FPBL_DARK_MS - 1) begin
							dark_ms_r <= 10'h000;
							st_r      <= ST_RUN;
						end else begin
							dark_ms_r <= dark_ms_r + 10'h001;
						end
					end
				end
				ST_RUN: begin
					// sel1 acts at once; sel2 and audio wait for a partner
					if (p1) begin
						if (lock_r) begin
							fl_cnt_r  <= halves(`FPBL_DENY_BLINKS);	// R16
							fl_half_r <= `FPBL_QUICK_HALF_MS;
							fl_ms_r   <= 8'h00;
							fl_on_r   <= 1'b1;
						end else begin
							sel1_r <= next_sel(sel1_r);	// R5
						end
					end
					if (pair) begin
						lock_r    <= ~lock_r;	// R15
						pend2_r   <= 1'b0;
						penda_r   <= 1'b0;
						fl_cnt_r  <= halves(`FPBL_LOCK_BLINKS);	// R15
						fl_half_r <= `FPBL_FLASH_HALF_MS;
						fl_ms_r   <= 8'h00;
						fl_on_r   <= 1'b1;
					end else if (p2 || pa) begin
						pend2_r <= pend2_r | p2;
						penda_r <= penda_r | pa;
						if (!pend2_r && !penda_r)
							win_r <= 7'h00;
					end else if (win_end && (pend2_r || penda_r)) begin
						pend2_r <= 1'b0;
						penda_r <= 1'b0;
						if (lock_r) begin
							fl_cnt_r  <= halves(`FPBL_DENY_BLINKS);	// R16
							fl_half_r <= `FPBL_QUICK_HALF_MS;
							fl_ms_r   <= 8'h00;
							fl_on_r   <= 1'b1;
						end else begin
							if (pend2_r)
								sel2_r <= next_sel(sel2_r);	// R5
							if (penda_r) begin
								preset_r <= preset_r + 2'h1;	// R7
								am_cnt_r <= halves(`FPBL_AMBER_BLINKS);	// R8
								am_ms_r  <= 8'h00;
							end
						end
					end else if (tick_r && (pend2_r || penda_r)) begin
						win_r <= win_r + 7'h01;
					end
					// long holds, counted only while unlocked
					if (!lvla || lock_r)
						hold_a_r <= 14'h0000;
					else if (tick_r && hold_a_r != `FPBL_HOLD_FAC_MS)
						hold_a_r <= hold_a_r + 14'h0001;
					if (!lvl1 || lock_r)
						hold_1_r <= 14'h0000;
					else if (tick_r && hold_1_r != `FPBL_DHCP_MS)
						hold_1_r <= hold_1_r + 14'h0001;
					if (hold_a_r == `FPBL_HOLD_FAC_MS) begin
						factory_req_r <= 1'b1;	// R11
						fac_r         <= 1'b1;	// R12
						st_r          <= ST_DARK;	// R12
					end else if (hold_1_r == `FPBL_DHCP_MS) begin
						dhcp_en_r <= 1'b1;	// R10
						hold_1_r  <= 14'h0000;
						dark_ms_r <= 10'h000;
						st_r      <= ST_DARK;	// R10
					end
				end
				default: begin
					st_r <= ST_BOOT;
				end
			endcase
		end
	end

	// audio routing per preset
	always @(posedge mclk) begin
		if (srst) begin
			route_out1_r   <= `FPBL_RT_OUT1;
			route_second_output_select_r   <= `FPBL_RT_OUT1;
			route_analog_r <= `FPBL_RT_OUT1;
		end else begin
			case (preset_r)
				2'h0: begin	// copy output 1 audio everywhere
					route_out1_r   <= `FPBL_RT_OUT1;	// R9
					route_second_output_select_r   <= `FPBL_RT_OUT1;
					route_analog_r <= `FPBL_RT_OUT1;
				end
				2'h2: begin	// analog input to all outputs
					route_out1_r   <= `FPBL_RT_ANALOG;	// R9
					route_second_output_select_r   <= `FPBL_RT_ANALOG;
					route_analog_r <= `FPBL_RT_ANALOG;
				end
				2'h3: begin	// originals kept, output 2 de-embedded
					route_out1_r   <= `FPBL_RT_OUT1;	// R9
					route_second_output_select_r   <= `FPBL_RT_SECOND_OUTPUT_SELECT;
					route_analog_r <= `FPBL_RT_SECOND_OUTPUT_SELECT;
				end
				default: begin	// preset 2: untouched streams
					route_out1_r   <= `FPBL_RT_ORIG;
					route_second_output_select_r   <= `FPBL_RT_ORIG;
					route_analog_r <= `FPBL_RT_ORIG;
				end
			endcase
		end
	end

	// indicators: every one is a flop, dark outside normal running except the heartbeat in upgrade mode
	always @(posedge mclk) begin : leds
		integer i;
		if (srst) begin
			led_in_r              <= 4'h0;
			led_tp_r              <= 1'b0;
			led_out_r             <= 2'h0;
			led_prot_r            <= 2'h0;
			heartbeat_indicator_r <= 1'b0;
			led_auto_r            <= 2'h0;
			led_sel_green_r       <= 4'h0;
			led_sel_amber_r       <= 4'h0;
		end else if (st_r != ST_RUN) begin
			led_in_r              <= 4'h0;	// R18
			led_tp_r              <= 1'b0;
			led_out_r             <= 2'h0;
			led_prot_r            <= 2'h0;
			heartbeat_indicator_r <= (st_r == ST_FW) & fast_r;	// R18
			led_auto_r            <= 2'h0;	// R12
			led_sel_green_r       <= 4'h0;
			led_sel_amber_r       <= 4'h0;
		end else begin
			heartbeat_indicator_r <= slow_r;	// R19 R14
			led_in_r              <= in_sig;	// R1
			led_tp_r              <= tp_link | (tp_lowpwr & slow_r);	// R2
			led_out_r             <= out_sig & ~out_mute;	// R3
			led_prot_r            <= (out_enc & ~out_incap) | (out_incap & {2{slow_r}});	// R4
			if (hold_blink) begin
				led_auto_r      <= {2{fast_r}};	// R11
				led_sel_green_r <= {4{fast_r}};	// R11
			end else if (fl_cnt_r != 4'h0) begin
				led_auto_r      <= {2{fl_on_r}};
				led_sel_green_r <= {4{fl_on_r}};
			end else begin
				led_auto_r <= {sel2_r == `FPBL_SEL_AUTO, sel1_r == `FPBL_SEL_AUTO};
				for (i = 0; i < 4; i = i + 1) begin
					// selected input: steady with signal, blinking without
					led_sel_green_r[i] <= ((sel1_r == i[2:0]) | (sel2_r == i[2:0])) & (in_sig[i] | slow_r);
				end
			end
			for (i = 0; i < 4; i = i + 1) begin
				led_sel_amber_r[i] <= (am_cnt_r != 4'h0) & ~am_cnt_r[0] & (preset_r == i[1:0]);	// R8
			end
		end
	end

	// register reads: data in the cycle after the strobe
	always @(posedge mclk) begin
		if (srst) begin
			reg_rdata_r <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				`FPBL_REG_CTRL:   reg_rdata_r <= {6'h00, lock_r, dhcp_en_r};
				`FPBL_REG_STATUS: reg_rdata_r <= {fw_mode_r, fac_r, st_r[1], lvlr, lock_r, 1'b0, preset_r};
				`FPBL_REG_SEL:    reg_rdata_r <= {1'b0, sel2_r, 1'b0, sel1_r};
				default:          reg_rdata_r <= 8'h00;	// unmapped reads zero
			endcase
		end else begin
			reg_rdata_r <= 8'h00;
		end
	end
endmodule // fpbl_ctrl

// [testbench/fpbl_panel.sv]
`timescale 1ns/1ns
// push buttons: contacts chatter for a dozen clocks after every change
module fpbl_panel (
	// clock
	input  wire       mclk,
	// finger on each button: sel1, sel2, audio, reset
	input  wire [3:0] hold,
	// contact level seen by the controller
	output reg  [3:0] pins
);
	reg [3:0] hold_r = 4'h0;	// request seen last cycle
	reg [3:0] bnc_r  = 4'h0;	// chatter countdown
	initial pins = 4'h0;
	// chatter stays far below the filter time, so one press must still count once
	always @(posedge mclk) begin
		hold_r <= hold;
		if (hold != hold_r) begin
			bnc_r <= 4'hC;
		end else if (bnc_r != 4'h0) begin
			bnc_r <= bnc_r - 4'h1;
		end
		pins <= (bnc_r[0] == 1'b1) ? ~hold : hold;
	end
endmodule // fpbl_panel

// [testbench/fpbl_ctrl_asserts.sv]
`timescale 1ns/1ns
// port-level checker for the panel controller
module fpbl_ctrl_chk #(
	parameter MS_CYC = 20000	// clocks per millisecond
) (
	// clock and reset
	input logic       mclk,
	input logic       srst,
	// buttons and status
	input logic       btn_sel1,
	input logic       btn_reset,
	input logic [3:0] in_sig,
	input logic       tp_link,
	input logic       tp_lowpwr,
	input logic [1:0] out_sig,
	input logic [1:0] out_mute,
	input logic [1:0] out_enc,
	input logic [1:0] out_incap,
	// indicators and requests
	input logic [3:0] led_in_r,
	input logic       led_tp_r,
	input logic [1:0] led_out_r,
	input logic [1:0] led_prot_r,
	input logic       heartbeat_indicator_r,
	input logic [1:0] led_auto_r,
	input logic [3:0] led_sel_green_r,
	input logic [2:0] sel1_r,
	input logic       dhcp_en_r,
	input logic       reboot_req_r,
	input logic       fw_mode_r
);
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	logic [31:0] hb_run_r;	// cycles since the heartbeat last moved
	logic        hb_old_r;	// heartbeat one cycle back
	// a long run means the heartbeat blinks too slowly
	always @(posedge mclk) begin
		hb_old_r <= heartbeat_indicator_r;
		if (srst || hb_old_r != heartbeat_indicator_r) begin
			hb_run_r <= 32'h0;
		end else begin
			hb_run_r <= hb_run_r + 32'h1;
		end
	end
	a_in_dark: assert property ((led_in_r & ~$past(in_sig)) == 4'h0)
		else $error("input led lit without signal");
	a_link_dark: assert property (led_tp_r |-> $past(tp_link | tp_lowpwr))
		else $error("link led lit without link");
	a_out_dark: assert property ((led_out_r & ~$past(out_sig & ~out_mute)) == 2'h0)
		else $error("output led lit while absent or muted");
	a_prot_dark: assert property ((led_prot_r & ~$past(out_enc | out_incap)) == 2'h0)
		else $error("protection led lit on clear output");
	a_sel_step: assert property ($changed(sel1_r) |-> $past(btn_sel1) &&
		sel1_r == (($past(sel1_r) == 3'h4) ? 3'h0 : $past(sel1_r) + 3'h1)) else $error("output one source misstep");
	a_dhcp_static: assert property ($fell(srst) |-> !dhcp_en_r)
		else $error("dynamic addressing on after reset");
	a_reboot_pulse: assert property (reboot_req_r |-> $past(btn_reset) ##1 !reboot_req_r)
		else $error("reboot request without reset button");
	a_upgrade_dark: assert property (fw_mode_r && $past(fw_mode_r, 2) |->
		{led_in_r, led_tp_r, led_out_r, led_prot_r, led_auto_r, led_sel_green_r} == 15'h0) else $error("led lit in upgrade");
	a_hb_fast: assert property (fw_mode_r |-> hb_run_r < 250 * MS_CYC)
		else $error("upgrade heartbeat too slow");
	c_upgrade: cover property ($rose(fw_mode_r));
	c_step: cover property ($changed(sel1_r));
	c_reboot: cover property (reboot_req_r);
endmodule // fpbl_ctrl_chk
bind fpbl_ctrl fpbl_ctrl_chk #(.MS_CYC(MS_CYC)) chk_u (.*);

// [testbench/tb_top.sv]
`timescale 1ns/1ns
`include "fpbl_map.vh"
module tb_top;
	localparam MS = 2;	// short millisecond keeps the long holds affordable
	logic       mclk, srst = 1'b1, wr_s = 1'b0, rd_s = 1'b0, tp_link = 1'b0, tp_lp = 1'b0;
	logic [3:0] addr = 4'h0, hold = 4'h0, in_sig = 4'h0, pins, led_in, grn, amb;
	logic [7:0] wdata = 8'h00, rdata;
	logic [1:0] o_sig = 2'h0, o_mute = 2'h0, o_enc = 2'h0, o_inc = 2'h0, led_out, led_prot, led_auto, r1, r2, ra;
	logic [2:0] sel1, sel2;
	logic       led_tp, hb, dhcp, fac, rbt, fw;
	integer     error_cnt = 0, checks = 0, rbt_cnt = 0, fac_cnt = 0;
	fpbl_ctrl #(.MS_CYC(MS)) dut_u (
		.mclk(mclk), .srst(srst), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr_s), .reg_rd(rd_s),
		.reg_rdata_r(rdata), .btn_sel1(pins[0]), .btn_sel2(pins[1]), .btn_audio(pins[2]), .btn_reset(pins[3]),
		.in_sig(in_sig), .tp_link(tp_link), .tp_lowpwr(tp_lp), .out_sig(o_sig), .out_mute(o_mute),
		.out_enc(o_enc), .out_incap(o_inc), .led_in_r(led_in), .led_tp_r(led_tp), .led_out_r(led_out),
		.led_prot_r(led_prot), .heartbeat_indicator_r(hb), .led_auto_r(led_auto), .led_sel_green_r(grn),
		.led_sel_amber_r(amb), .sel1_r(sel1), .sel2_r(sel2), .route_out1_r(r1), .route_second_output_select_r(r2),
		.route_analog_r(ra), .dhcp_en_r(dhcp), .factory_req_r(fac), .reboot_req_r(rbt), .fw_mode_r(fw));
	fpbl_panel panel_u (.mclk(mclk), .hold(hold), .pins(pins));
	// 20 MHz clock
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	// count reboot and factory request pulses
	always @(posedge mclk) begin
		if (rbt === 1'b1) rbt_cnt++;
		if (fac === 1'b1) fac_cnt++;
	end
	task automatic tick(input integer n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// a wait that ran out ends the run at once
	task automatic bound(input logic ok, input string what);
		if (ok !== 1'b1) begin
			chk(what, 8'h01, 8'h00);
			summarize;
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		tick(1);
		wr_s <= 1'b0;
	endtask
	// data are taken in the one cycle where they stand
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		addr <= a;
		rd_s <= 1'b1;
		tick(1);
		rd_s <= 1'b0;
		tick(1);
		d = rdata;
	endtask
	task automatic press(input integer b, input integer on_ms, input integer off_ms);
		hold[b] <= 1'b1;
		tick(on_ms * MS);
		hold[b] <= 1'b0;
		tick(off_ms * MS);
	endtask
	task automatic rises(input integer ms, output integer c);
		logic v;
		c = 0;
		repeat (ms * MS) begin
			v = led_auto[1];
			tick(1);
			if (led_auto[1] === 1'b1 && v === 1'b0) c++;
		end
	endtask
	task automatic hb_half(output integer n);
		logic v;
		n = 0;
		v = hb;
		repeat (1100 * MS) if (hb === v) tick(1);
		v = hb;
		while (hb === v && n < 1100 * MS) begin
			tick(1);
			n++;
		end
		bound(n < 1100 * MS, "heartbeat moves");
	endtask
	task automatic t_status;
		in_sig <= 4'h5;
		tp_link <= 1'b1;
		o_sig <= 2'h3;
		o_mute <= 2'h2;
		o_enc <= 2'h1;
		tick(4);
		chk("input leds", 8'h05, led_in);
		chk("link led", 8'h01, led_tp);
		chk("output leds", 8'h01, led_out);
		chk("protect leds", 8'h01, led_prot);
		tp_link <= 1'b0;
		in_sig <= 4'hA;
		tick(4);
		chk("input leds", 8'h0A, led_in);
		chk("link led", 8'h00, led_tp);
		$display("test status leds done");
	endtask
	task automatic t_regs;
		logic [7:0] d;
		wr(`FPBL_REG_CTRL, 8'h01);
		tick(1);
		chk("dynamic addressing", 8'h01, dhcp);
		rd(`FPBL_REG_CTRL, d);
		chk("ctrl reg", 8'h01, d);
		wr(`FPBL_REG_STATUS, 8'hFF);
		rd(`FPBL_REG_STATUS, d);
		chk("status reg", 8'h20, d);
		rd(4'hC, d);
		chk("unmapped reg", 8'h00, d);
		wr(`FPBL_REG_CTRL, 8'h00);
		$display("test registers done");
	endtask
	task automatic t_select;
		integer k;
		logic [7:0] d;
		for (k = 1; k < 6; k++) begin
			press(0, 30, 30);
			chk("source out1", k % 5, sel1);
			chk("auto led out1", k == 4, led_auto[0]);
		end
		press(1, 30, 130);
		chk("source second_output_select", 8'h01, sel2);
		rd(`FPBL_REG_SEL, d);
		chk("select reg", 8'h10, d);
		chk("select leds", 8'h02, grn & 4'hE);
		$display("test video select done");
	endtask
	// presets 2, 3, 4 and back to 1; routes packed as out1, second_output_select, analog
	task automatic t_audio;
		logic [5:0] rt [4] = '{6'h15, 6'h00, 6'h3F, 6'h1A};
		integer p, n, c;
		logic v;
		for (p = 1; p < 5; p++) begin
			n = p % 4;
			press(2, 30, 0);
			c = 0;
			repeat (3200 * MS) begin
				v = amb[n];
				tick(1);
				if (amb[n] === 1'b1 && v === 1'b0) c++;
			end
			chk("amber blinks", 8'h06, c);
			chk("audio routes", rt[n], {r1, r2, ra});
		end
		$display("test audio presets done");
	endtask
	task automatic pair(input logic lk);
		integer c;
		logic [7:0] d;
		hold[2:1] <= 2'h3;
		rises(2300, c);
		hold[2:1] <= 2'h0;
		tick(40 * MS);
		chk("lock blinks", 8'h04, c);
		rd(`FPBL_REG_STATUS, d);
		chk("lock bit", lk, d[3]);
	endtask
	task automatic t_lock;
		integer c;
		pair(1'b1);
		hold[0] <= 1'b1;
		rises(900, c);
		hold[0] <= 1'b0;
		tick(40 * MS);
		chk("refusal blinks", 8'h03, c);
		chk("source while locked", 8'h00, sel1);
		pair(1'b0);
		$display("test control lock done");
	endtask
	task automatic t_reboot;
		integer n;
		press(3, 30, 30);
		chk("reboot pulses", 8'h01, rbt_cnt);
		chk("sources kept", 8'h10, {1'b0, sel2, 1'b0, sel1});
		hb_half(n);
		chk("slow half period", 8'd50, n / (10 * MS));
		$display("test reset button done");
	endtask
	// sel1 held long: addressing goes dynamic, leds dark for a while
	task automatic t_dhcp;
		hold[0] <= 1'b1;
		tick(5100 * MS);
		chk("dynamic addressing", 8'h01, dhcp);
		chk("dark input leds", 8'h00, led_in);
		hold[0] <= 1'b0;
		tick(1100 * MS);
		chk("input leds", 8'h0A, led_in);
		$display("test dhcp gesture done");
	endtask
	// audio held long: front leds blink fast, then the factory request
	task automatic t_factory;
		integer c;
		hold[2] <= 1'b1;
		tick(5100 * MS);
		rises(4000, c);
		tick(1000 * MS);
		hold[2] <= 1'b0;
		chk("hold blinks", 8'd20, c);
		chk("factory pulses", 8'h01, fac_cnt);
		chk("dark leds", 8'h00, {hb, led_in, led_auto});
		$display("test factory reset done");
	endtask
	task automatic t_upgrade;
		integer n;
		srst <= 1'b1;
		hold[2] <= 1'b1;
		tick(8);
		srst <= 1'b0;
		tick(80 * MS);
		chk("upgrade mode", 8'h01, fw);
		hb_half(n);
		chk("fast half period", 8'd10, n / (10 * MS));
		chk("input leds", 8'h00, led_in);
		hold[2] <= 1'b0;
		srst <= 1'b1;
		tick(8);
		srst <= 1'b0;
		tick(80 * MS);
		chk("upgrade mode", 8'h00, fw);
		$display("test upgrade entry done");
	endtask
	initial begin
		#5000000;
		bound(1'b0, "run time");
	end
	initial begin
		tick(8);
		srst <= 1'b0;
		tick(50 * MS);
		chk("dynamic addressing", 8'h00, dhcp);
		t_status;
		t_regs;
		t_select;
		t_audio;
		t_lock;
		t_reboot;
		t_dhcp;
		t_factory;
		t_upgrade;
		summarize;
	end
endmodule // tb_top
